// ===== logic/atpt_taskfile_access.sv
// The AXI4-Lite slave port and the address map were left to the implementer.
`default_nettype none
`include "atpt_map.svh"
module atpt_taskfile_access import atpt_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic ata_req,
    output logic ata_wr,
    output logic [9:0] ata_addr,
    output logic [7:0] ata_wdata,
    input wire logic ata_ack,
    input wire logic [7:0] ata_rdata,
    output logic xfer_req,
    input wire logic xfer_done
);
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic aw_hold_ff, w_hold_ff;
    logic [31:0] awaddr_ff, wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [7:0] cb_ff [0:15];
    logic [7:0] rb_ff [0:7];
    logic [7:0] sig_ff;
    logic start_ff, done_ff, rejected_ff;
    atpt_state_t state_ff;
    logic [3:0] step_ff;
    logic poll_ff, rb_mode_ff, sel_after_ff;
    logic req_ff, wr_ff, xfer_ff;
    logic [9:0] addr_ff;
    logic [7:0] wd_ff;
    logic [2:0] cur_idx_ff, map_idx, iss_idx;
    logic wr_fire, wr_hit, block_ok, done_set, done_clr, iss_go;
    logic [31:0] rd_data;
    logic rd_hit;
    logic [7:0] act, mask;

    assign act = cb_ff[`ATPT_CB_ACT];
    assign mask = cb_ff[`ATPT_CB_MASK];
    assign block_ok = (cb_ff[`ATPT_CB_SIG] == sig_ff) &&
                      (cb_ff[`ATPT_CB_SUB] == `ATPT_SUBCMD);
    assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;

    atpt_order_map u_order (
        .step(step_ff[2:0]),
        .sel_after(sel_after_ff),
        .rb_mode(rb_mode_ff),
        .reg_idx(map_idx)
    );

    // Write decode of the held address
    always_comb begin
        wr_hit = 1'b1;
        if (awaddr_ff[31:4] == `ATPT_ADDR_CB0 >> 4) begin
            wr_hit = 1'b1;
        end else if (awaddr_ff == `ATPT_ADDR_CTRL) begin
            wr_hit = 1'b1;
        end else if (awaddr_ff == `ATPT_ADDR_STAT) begin
            wr_hit = 1'b1;
        end else if (awaddr_ff == `ATPT_ADDR_SIG) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
        if (awaddr_ff[1:0] != 2'h0) begin
            wr_hit = 1'b0;
        end
    end

    // AXI write channels: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `ATPT_RESP_OKAY;
            awaddr_ff <= 32'h0000_0000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_ff) begin
                awaddr_ff <= s_axi_awaddr;
                aw_hold_ff <= 1'b1;
                awready_ff <= 1'b0;
            end
            if (s_axi_wvalid && wready_ff) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                w_hold_ff <= 1'b1;
                wready_ff <= 1'b0;
            end
            if (wr_fire) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? `ATPT_RESP_OKAY : `ATPT_RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // Command block bytes and signature setting, per byte lane
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 16; i++) begin
                cb_ff[i] <= 8'h00;
            end
            sig_ff <= `ATPT_SIG_RST;
        end else if (wr_fire && wr_hit) begin
            for (int l = 0; l < 4; l++) begin
                if (wstrb_ff[l] &&
                    awaddr_ff[31:4] == `ATPT_ADDR_CB0 >> 4) begin
                    cb_ff[{awaddr_ff[3:2], 2'(l)}] <= wdata_ff[8*l +: 8];
                end
            end
            if (awaddr_ff == `ATPT_ADDR_SIG && wstrb_ff[0]) begin
                sig_ff <= wdata_ff[7:0];
            end
        end
    end

    // Start pulse; ignored while an operation runs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_ff <= 1'b0;
        end else begin
            start_ff <= wr_fire && awaddr_ff == `ATPT_ADDR_CTRL &&
                        wstrb_ff[0] && wdata_ff[`ATPT_CTRL_START] &&
                        state_ff == ATPT_IDLE;
        end
    end

    // Done flag: hardware set wins over software clear
    assign done_clr = wr_fire && awaddr_ff == `ATPT_ADDR_STAT &&
                      wstrb_ff[0] && wdata_ff[`ATPT_ST_DONE];
    assign done_set = (state_ff == ATPT_CHECK && !block_ok) ||
                      (state_ff == ATPT_ISSUE && !poll_ff &&
                       step_ff == `ATPT_STEPS && rb_mode_ff) ||
                      (state_ff == ATPT_XFER && xfer_done);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_ff <= 1'b0;
        end else if (done_set) begin
            done_ff <= 1'b1;
        end else if (done_clr) begin
            done_ff <= 1'b0;
        end
    end

    // Read decode
    always_comb begin
        rd_hit = 1'b1;
        rd_data = 32'h0000_0000;
        if (s_axi_araddr[31:4] == `ATPT_ADDR_CB0 >> 4 &&
            s_axi_araddr[1:0] == 2'h0) begin
            for (int l = 0; l < 4; l++) begin
                rd_data[8*l +: 8] = cb_ff[{s_axi_araddr[3:2], 2'(l)}];
            end
        end else if (s_axi_araddr == `ATPT_ADDR_CTRL) begin
            rd_data = 32'h0000_0000;
        end else if (s_axi_araddr == `ATPT_ADDR_STAT) begin
            rd_data[`ATPT_ST_BUSY] = state_ff != ATPT_IDLE;
            rd_data[`ATPT_ST_DONE] = done_ff;
            rd_data[`ATPT_ST_REJ] = rejected_ff;
            rd_data[`ATPT_ST_XFER] = xfer_ff;
        end else if (s_axi_araddr == `ATPT_ADDR_RBLO) begin
            rd_data = {rb_ff[3], rb_ff[2], rb_ff[1], rb_ff[0]};
        end else if (s_axi_araddr == `ATPT_ADDR_RBHI) begin
            rd_data = {rb_ff[7], rb_ff[6], rb_ff[5], rb_ff[4]};
        end else if (s_axi_araddr == `ATPT_ADDR_SIG) begin
            rd_data[7:0] = sig_ff;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // AXI read channel, answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `ATPT_RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_data;
            rresp_ff <= rd_hit ? `ATPT_RESP_OKAY : `ATPT_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // Next taskfile access: busy poll first, then selected steps
    assign iss_go = state_ff == ATPT_ISSUE && (poll_ff ||
                    (step_ff < `ATPT_STEPS && mask[map_idx]));
    assign iss_idx = poll_ff ? 3'h0 : map_idx;

    // Sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ATPT_IDLE;
            step_ff <= 4'h0;
            poll_ff <= 1'b0;
            rb_mode_ff <= 1'b0;
            sel_after_ff <= 1'b0;
            rejected_ff <= 1'b0;
            xfer_ff <= 1'b0;
        end else begin
            case (state_ff)
                ATPT_IDLE: begin
                    if (start_ff) begin
                        state_ff <= ATPT_CHECK;
                    end
                end
                ATPT_CHECK: begin
                    step_ff <= 4'h0;
                    rejected_ff <= !block_ok;
                    poll_ff <= !act[`ATPT_ACT_SKIPPOLL];
                    rb_mode_ff <= act[`ATPT_ACT_RBONLY];
                    sel_after_ff <= act[`ATPT_ACT_SELAFT];
                    state_ff <= block_ok ? ATPT_ISSUE : ATPT_IDLE;
                end
                ATPT_ISSUE: begin
                    if (iss_go) begin
                        state_ff <= ATPT_WAIT;
                    end
                    if (!poll_ff) begin
                        if (step_ff == `ATPT_STEPS) begin
                            xfer_ff <= !rb_mode_ff;
                            state_ff <= rb_mode_ff ? ATPT_IDLE : ATPT_XFER;
                        end else begin
                            step_ff <= step_ff + 4'h1;
                        end
                    end
                end
                ATPT_WAIT: begin
                    if (ata_ack) begin
                        if (poll_ff && !ata_rdata[`ATPT_BSY_BIT]) begin
                            poll_ff <= 1'b0;
                        end
                        state_ff <= ATPT_ISSUE;
                    end
                end
                ATPT_XFER: begin
                    if (xfer_done) begin
                        xfer_ff <= 1'b0;
                        state_ff <= ATPT_IDLE;
                    end
                end
                default: begin
                    state_ff <= ATPT_IDLE;
                end
            endcase
        end
    end

    // Taskfile access port, request held until acknowledged
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_ff <= 1'b0;
            wr_ff <= 1'b0;
            addr_ff <= 10'h000;
            wd_ff <= 8'h00;
            cur_idx_ff <= 3'h0;
        end else if (iss_go) begin
            req_ff <= 1'b1;
            wr_ff <= !poll_ff && !rb_mode_ff;
            cur_idx_ff <= iss_idx;
            addr_ff <= (iss_idx == 3'h0) ? `ATPT_ALT_ADDR :
                       `ATPT_TF_BASE + {7'h00, iss_idx};
            wd_ff <= cb_ff[`ATPT_CB_WDATA + {1'b0, iss_idx}];
        end else if (state_ff == ATPT_WAIT && ata_ack) begin
            req_ff <= 1'b0;
        end
    end

    // Readback bytes, cleared per operation so unselected read zero
    always_ff @(posedge aclk) begin
        if (!aresetn || state_ff == ATPT_CHECK) begin
            for (int i = 0; i < 8; i++) begin
                rb_ff[i] <= 8'h00;
            end
        end else if (state_ff == ATPT_WAIT && ata_ack && !poll_ff &&
                     rb_mode_ff) begin
            rb_ff[cur_idx_ff] <= ata_rdata;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign ata_req = req_ff;
    assign ata_wr = wr_ff;
    assign ata_addr = addr_ff;
    assign ata_wdata = wd_ff;
    assign xfer_req = xfer_ff;

    // Helper state for checks
    logic sel_done_ff, cmd_done_ff, rb_nz;
    always_ff @(posedge aclk) begin
        if (!aresetn || state_ff == ATPT_CHECK) begin
            sel_done_ff <= 1'b0;
            cmd_done_ff <= 1'b0;
        end else if (req_ff && ata_ack && wr_ff) begin
            if (cur_idx_ff == `ATPT_DEVHEAD_IDX) sel_done_ff <= 1'b1;
            if (cur_idx_ff == `ATPT_CMD_IDX) cmd_done_ff <= 1'b1;
        end
    end
    always_comb begin
        rb_nz = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rb_nz = rb_nz | (!mask[i] && rb_ff[i] != 8'h00);
        end
    end

    // Last readback index, for the ascending order check
    logic [2:0] last_rd_ff;
    logic rd_seen_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn || state_ff == ATPT_CHECK) begin
            last_rd_ff <= 3'h0;
            rd_seen_ff <= 1'b0;
        end else if (req_ff && ata_ack && rb_mode_ff && !poll_ff) begin
            last_rd_ff <= cur_idx_ff;
            rd_seen_ff <= 1'b1;
        end
    end

    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence cmd_write_s;
        $rose(req_ff) && wr_ff && cur_idx_ff == `ATPT_CMD_IDX;
    endsequence
    sequence sel_write_s;
        $rose(req_ff) && wr_ff && cur_idx_ff == `ATPT_DEVHEAD_IDX;
    endsequence

    select_first_a: assert property (
        cmd_write_s ##0 (!sel_after_ff && mask[6]) |-> sel_done_ff)
        else $error("command before selection");
    select_after_a: assert property (
        sel_write_s ##0 (sel_after_ff && mask[7]) |-> cmd_done_ff)
        else $error("selection before command");
    readback_nowrite_a: assert property (rb_mode_ff && req_ff
        |-> !wr_ff) else $error("write in readback mode");
    xfer_start_a: assert property (
        state_ff == ATPT_ISSUE && !poll_ff &&
        step_ff == `ATPT_STEPS && !rb_mode_ff |=> xfer_req)
        else $error("data phase not requested");
    ascend_order_a: assert property ($rose(req_ff) && rb_mode_ff &&
        !poll_ff && rd_seen_ff |-> cur_idx_ff > last_rd_ff)
        else $error("readback out of order");
    zero_fill_a: assert property ($rose(done_ff) && rb_mode_ff &&
        !rejected_ff |-> !rb_nz) else $error("unselected byte not zero");
    reg_select_a: assert property (req_ff && !poll_ff |->
        mask[cur_idx_ff] && ata_addr == ((cur_idx_ff == 3'h0) ?
        `ATPT_ALT_ADDR : `ATPT_TF_BASE + {7'h00, cur_idx_ff}))
        else $error("unselected or misaddressed access");
    reject_block_a: assert property (
        state_ff == ATPT_CHECK && !block_ok
        |=> (rejected_ff && done_ff && !req_ff) [*2])
        else $error("bad block not rejected");
    busy_poll_a: assert property (
        state_ff == ATPT_CHECK && block_ok &&
        !act[`ATPT_ACT_SKIPPOLL] |-> ##2 req_ff && !wr_ff &&
        ata_addr == `ATPT_ALT_ADDR) else $error("busy poll missing");
endmodule : atpt_taskfile_access
`default_nettype wire

// ===== shared/atpt_map.svh
`ifndef ATPT_MAP_SVH
`define ATPT_MAP_SVH

// Register byte addresses on the AXI4-Lite slave
`define ATPT_ADDR_CB0 32'h0000_0000
`define ATPT_ADDR_CB1 32'h0000_0004
`define ATPT_ADDR_CB2 32'h0000_0008
`define ATPT_ADDR_CB3 32'h0000_000C
`define ATPT_ADDR_CTRL 32'h0000_0010
`define ATPT_ADDR_STAT 32'h0000_0014
`define ATPT_ADDR_RBLO 32'h0000_0018
`define ATPT_ADDR_RBHI 32'h0000_001C
`define ATPT_ADDR_SIG 32'h0000_0020

// Field positions
`define ATPT_CTRL_START 0
`define ATPT_ST_BUSY 0
`define ATPT_ST_DONE 1
`define ATPT_ST_REJ 2
`define ATPT_ST_XFER 3
`define ATPT_ACT_RBONLY 0
`define ATPT_ACT_SELAFT 1
`define ATPT_ACT_SKIPPOLL 2
`define ATPT_BSY_BIT 7

// Command block layout
`define ATPT_CB_SIG 4'h0
`define ATPT_CB_SUB 4'h1
`define ATPT_CB_ACT 4'h2
`define ATPT_CB_MASK 4'h3
`define ATPT_CB_WDATA 4'h5
`define ATPT_SUBCMD 8'h24
`define ATPT_SIG_RST 8'h5A

// Taskfile addressing and sequencing
`define ATPT_ALT_ADDR 10'h3F6
`define ATPT_TF_BASE 10'h1F0
`define ATPT_DEVHEAD_IDX 3'h6
`define ATPT_CMD_IDX 3'h7
`define ATPT_STEPS 4'h8

// AXI responses
`define ATPT_RESP_OKAY 2'h0
`define ATPT_RESP_SLVERR 2'h2

`endif

// ===== shared/atpt_pkg.sv
`default_nettype none
package atpt_pkg;
    // Sequencer states
    typedef enum logic [2:0] {
        ATPT_IDLE,
        ATPT_CHECK,
        ATPT_ISSUE,
        ATPT_WAIT,
        ATPT_XFER
    } atpt_state_t;
endpackage : atpt_pkg
`default_nettype wire

// ===== logic/atpt_order_map.sv
`default_nettype none
`include "atpt_map.svh"
module atpt_order_map import atpt_pkg::*; (
    input wire logic [2:0] step,
    input wire logic sel_after,
    input wire logic rb_mode,
    output logic [2:0] reg_idx
);
    // Step number to taskfile register index
    always_comb begin
        if (rb_mode) begin
            reg_idx = step;
        end else if (!sel_after) begin
            // Device/head first, then the rest in order
            if (step == 3'h0) begin
                reg_idx = `ATPT_DEVHEAD_IDX;
            end else if (step < 3'h7) begin
                reg_idx = step - 3'h1;
            end else begin
                reg_idx = `ATPT_CMD_IDX;
            end
        end else begin
            // Device/head moved after the command write
            if (step < 3'h6) begin
                reg_idx = step;
            end else if (step == 3'h6) begin
                reg_idx = `ATPT_CMD_IDX;
            end else begin
                reg_idx = `ATPT_DEVHEAD_IDX;
            end
        end
    end
endmodule : atpt_order_map
`default_nettype wire

// ===== verification/atpt_drive_model.sv
`default_nettype none
module atpt_drive_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ata_req,
    input wire logic ata_wr,
    input wire logic [9:0] ata_addr,
    input wire logic [7:0] ata_wdata,
    input wire logic xfer_req,
    input wire logic [1:0] ack_dly,
    input wire logic [3:0] busy_polls,
    output logic ata_ack,
    output logic [7:0] ata_rdata,
    output logic xfer_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tf [8];
    logic [11:0] lg [64];
    logic [2:0] idx;
    logic [7:0] rv;
    int n_acc, n_xfer, cnt, polls, xc;

    // Register index from the taskfile address
    assign idx = (ata_addr == 10'h3F6) ? 3'h0 : ata_addr[2:0];

    // Alternate status reports busy for the first polls
    always_comb begin
        if (idx == 3'h0 && polls < int'(busy_polls)) rv = 8'h80;
        else if (idx == 3'h0 || idx == 3'h7) rv = 8'h50;
        else rv = tf[idx];
    end

    // Acknowledge each access after ack_dly cycles and log it
    always @(posedge aclk) begin
        if (!aresetn) begin
            ata_ack <= 1'b0;
            ata_rdata <= 8'h00;
            cnt <= 0;
            polls <= 0;
            n_acc <= 0;
            for (int i = 0; i < 8; i++) tf[i] <= 8'hA0 + 8'(i);
        end else if (ata_req && !ata_ack && cnt + 1 == int'(ack_dly)) begin
            ata_ack <= 1'b1;
            ata_rdata <= ata_wr ? ~ata_rdata : rv;
            lg[n_acc] <= {ata_wr, idx, ata_wr ? ata_wdata : rv};
            n_acc <= n_acc + 1;
            cnt <= 0;
            if (ata_wr) tf[idx] <= ata_wdata;
            else if (idx == 3'h0) polls <= polls + 1;
        end else begin
            ata_ack <= 1'b0;
            ata_rdata <= ~ata_rdata; // Stale data is inverted every cycle
            cnt <= (ata_req && !ata_ack) ? cnt + 1 : 0;
            if (busy_polls == 4'h0) polls <= 0;
        end
    end

    // Data phase ends five cycles after it is requested
    always @(posedge aclk) begin
        xfer_done <= 1'b0;
        if (!aresetn) begin
            xc <= 0;
            n_xfer <= 0;
        end else if (!xfer_req) xc <= 0;
        else if (xc < 4) xc <= xc + 1;
        else if (xc == 4) begin
            xfer_done <= 1'b1;
            xc <= 5;
            n_xfer <= n_xfer + 1;
        end
    end
endmodule : atpt_drive_model
`default_nettype wire

// ===== verification/ata_passthrough_taskfile_access_test.sv
`default_nettype none
`include "atpt_map.svh"
module ata_passthrough_taskfile_access_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000;
    logic [31:0] araddr = 32'h0000_0000;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic ata_req, ata_wr, ata_ack, xfer_req, xfer_done;
    logic [9:0] ata_addr;
    logic [7:0] ata_wdata, ata_rdata;
    logic [1:0] ack_dly = 2'h1;
    logic [3:0] busy_polls = 4'h0;
    logic [7:0] tfv [8];
    int bad_count = 0;
    int checked = 0;
    int base, xb;

    always #5 aclk = ~aclk;

    atpt_taskfile_access atpt_taskfile_access_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ata_req(ata_req), .ata_wr(ata_wr), .ata_addr(ata_addr),
        .ata_wdata(ata_wdata), .ata_ack(ata_ack), .ata_rdata(ata_rdata),
        .xfer_req(xfer_req), .xfer_done(xfer_done)
    );

    atpt_drive_model atpt_drive_model_inst (
        .aclk(aclk), .aresetn(aresetn), .ata_req(ata_req),
        .ata_wr(ata_wr), .ata_addr(ata_addr), .ata_wdata(ata_wdata),
        .xfer_req(xfer_req), .ack_dly(ack_dly), .busy_polls(busy_polls),
        .ata_ack(ata_ack), .ata_rdata(ata_rdata), .xfer_done(xfer_done)
    );

    task automatic end_sim;
        if (bad_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    // Write channels released as each is taken, answer awaited
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        int t;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (t = 0; t < 100; t++) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        r = bresp;
        bready <= 1'b0;
        if (t == 100) bad_count++;
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int t;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (t = 0; t < 100; t++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (t == 100) bad_count++;
    endtask : axi_rd

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        cmp(32'(r), 32'(`ATPT_RESP_OKAY));
    endtask : wr

    task automatic rd_cmp(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        cmp(d, e);
    endtask : rd_cmp

    function automatic logic [2:0] ord(input int k, input logic sa);
        if (!sa) return (k == 0) ? 3'h6 : (k == 7) ? 3'h7 : 3'(k - 1);
        return (k == 6) ? 3'h7 : (k == 7) ? 3'h6 : 3'(k);
    endfunction : ord

    function automatic logic [7:0] val(input logic [2:0] i);
        return (i == 3'h0 || i == 3'h7) ? 8'h50 : tfv[i];
    endfunction : val

    // Load the first word of the block, clear done, start it and wait for done
    task automatic run_op(input logic [7:0] sg, input logic [7:0] sb,
                          input logic [7:0] act, input logic [7:0] mk,
                          output logic [31:0] s);
        int k;
        logic [1:0] r;
        wr(`ATPT_ADDR_CB0, {mk, act, sb, sg});
        wr(`ATPT_ADDR_STAT, 32'h0000_0002);
        base = atpt_drive_model_inst.n_acc;
        xb = atpt_drive_model_inst.n_xfer;
        wr(`ATPT_ADDR_CTRL, 32'h0000_0001);
        for (k = 0; k < 300; k++) begin
            axi_rd(`ATPT_ADDR_STAT, s, r);
            if (s[1] === 1'b1) break;
        end
        if (k == 300) bad_count++;
    endtask : run_op

    // Expected access sequence, data phase and readback bytes
    task automatic chk_log(input logic [7:0] act, input logic [7:0] mk);
        int k, j;
        logic [2:0] i;
        logic [7:0] v;
        logic [63:0] rb;
        j = base;
        rb = 64'h0;
        for (k = 0; k < 8; k++) begin
            i = act[0] ? 3'(k) : ord(k, act[1]);
            v = act[0] ? val(i) : 8'h30 + 8'(i);
            if (mk[i] === 1'b1) begin
                cmp(32'(atpt_drive_model_inst.lg[j]),
                    32'({~act[0], i, v}));
                j++;
            end
            if (mk[k] === 1'b1) rb[8*k +: 8] = val(3'(k));
        end
        cmp(32'(atpt_drive_model_inst.n_acc), 32'(j));
        cmp(32'(atpt_drive_model_inst.n_xfer),
            32'(act[0] ? xb : xb + 1));
        if (act[0]) begin
            rd_cmp(`ATPT_ADDR_RBLO, rb[31:0]);
            rd_cmp(`ATPT_ADDR_RBHI, rb[63:32]);
        end
    endtask : chk_log

    initial begin
        logic [31:0] s;
        logic [1:0] r;
        logic [7:0] a, m;
        int k, j;
        for (k = 0; k < 8; k++) tfv[k] = 8'hA0 + 8'(k);
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd_cmp(`ATPT_ADDR_SIG, 32'(`ATPT_SIG_RST));
        rd_cmp(`ATPT_ADDR_STAT, 32'h0000_0000);
        axi_rd(32'h0000_0024, s, r);
        cmp(32'(r), 32'(`ATPT_RESP_SLVERR));
        axi_wr(32'h0000_0024, 32'h0000_0001, r);
        cmp(32'(r), 32'(`ATPT_RESP_SLVERR));
        wr(`ATPT_ADDR_CB1, 32'h3231_3000);
        wr(`ATPT_ADDR_CB2, 32'h3635_3433);
        wr(`ATPT_ADDR_CB3, 32'h0000_0037);
        // Byte lanes and the signature setting
        wstrb <= 4'h2;
        wr(`ATPT_ADDR_CB3, 32'hFFFF_FFFF);
        wstrb <= 4'hF;
        rd_cmp(`ATPT_ADDR_CB3, 32'h0000_FF37);
        wr(`ATPT_ADDR_CB3, 32'h0000_0037);
        wr(`ATPT_ADDR_SIG, 32'h0000_00C3);
        rd_cmp(`ATPT_ADDR_SIG, 32'h0000_00C3);
        wr(`ATPT_ADDR_SIG, 32'(`ATPT_SIG_RST));
        // Wrong signature, then wrong subcommand
        for (k = 0; k < 2; k++) begin
            a = k[0] ? `ATPT_SIG_RST : 8'h11;
            m = k[0] ? 8'h25 : `ATPT_SUBCMD;
            run_op(a, m, 8'h05, 8'hFF, s);
            cmp(s, 32'h0000_0006);
            cmp(32'(atpt_drive_model_inst.n_acc), 32'(base));
        end
        // Command runs with both selection orders, slow drive
        ack_dly <= 2'h3;
        for (k = 0; k < 4; k++) begin
            a = k[1] ? 8'h06 : 8'h04;
            m = k[0] ? 8'hB5 : 8'hFF;
            run_op(`ATPT_SIG_RST, `ATPT_SUBCMD, a, m, s);
            cmp(s, 32'h0000_0002);
            chk_log(a, m);
            for (j = 1; j < 7; j++) if (m[j]) tfv[j] = 8'h30 + 8'(j);
        end
        // Readback only, eight bytes expected by the host
        ack_dly <= 2'h1;
        for (k = 0; k < 4; k++) begin
            m = (k == 0) ? 8'h41 : (k == 1) ? 8'hFF : (k == 2) ? 8'h00 : 8'h80;
            run_op(`ATPT_SIG_RST, `ATPT_SUBCMD, 8'h05, m, s);
            cmp(s, 32'h0000_0002);
            chk_log(8'h05, m);
        end
        // Busy poll before the readback
        busy_polls <= 4'h2;
        run_op(`ATPT_SIG_RST, `ATPT_SUBCMD, 8'h01, 8'h01, s);
        cmp(32'(atpt_drive_model_inst.lg[base]), 32'h0000_0080);
        cmp(32'(atpt_drive_model_inst.lg[base + 1]), 32'h0000_0080);
        cmp(32'(atpt_drive_model_inst.lg[base + 2]), 32'h0000_0050);
        base = base + 3;
        chk_log(8'h01, 8'h01);
        busy_polls <= 4'h0;
        end_sim;
    end

    // Watchdog
    initial begin
        #500000;
        bad_count++;
        end_sim;
    end
endmodule : ata_passthrough_taskfile_access_test
`default_nettype wire
